/* shared/pxsc_regs.vh */
// Register map, field positions, reset values and timing constants
`ifndef PXSC_REGS_VH
`define PXSC_REGS_VH
`define PXSC_I2C_ADDR 7'h39
`define PXSC_A_ENABLE 5'h00
`define PXSC_A_CONVERSION_TIME 5'h02
`define PXSC_A_WTIME 5'h03
`define PXSC_A_DRVCFG 5'h0D
`define PXSC_A_PULSE_COUNT 5'h0E
`define PXSC_A_CTRL 5'h0F
`define PXSC_A_STATUS 5'h13
`define PXSC_A_PDATAL 5'h18
`define PXSC_A_PDATAH 5'h19
`define PXSC_A_OFFSET 5'h1E
`define PXSC_B_PON 0
`define PXSC_B_PEN 2
`define PXSC_B_WEN 3
`define PXSC_B_SAI 6
`define PXSC_B_PDL 0
`define PXSC_B_VALID 0
`define PXSC_B_PINT 5
`define PXSC_B_SATURATION_FLAG 6
`define PXSC_CMD_BIT 7
`define PXSC_TYPE_AUTO 2'h1
`define PXSC_TYPE_SF 2'h3
`define PXSC_SF_PCLR 5'h05
`define PXSC_RST_TIME 8'hFF
`define PXSC_RST_ZERO 8'h00
`define PXSC_FULL_SCALE 16'hFFFF
`define PXSC_LED_BASE 10'h3E8
`define PXSC_LED_DIV 10'h009
`define PXSC_ADC_MAX 13'h03FF
`define PXSC_UNITS_TOP 9'h100
`define PXSC_CLK_NS 10
`define PXSC_LED_ON_NS 7300
`define PXSC_LED_PER_NS 16000
`define PXSC_UNIT_NS 2730000
`endif

/* hw/pxsc_accum.v */
// LED pulse timing and background-subtracted pulse accumulation
`timescale 1ns/1ps
`include "pxsc_regs.vh"
module pxsc_accum #(
  parameter ON_CYC = 730,
  parameter PER_CYC = 1600
) (
  input wire clock_in,
  input wire reset_in,
  input wire start_in,
  input wire [7:0] pulses_in,
  input wire [1:0] gain_in,
  input wire [9:0] on_energy_in,
  input wire [9:0] off_energy_in,
  output reg led_on_out,
  output reg done_out,
  output reg sat_out,
  output reg [17:0] acc_out
);
  reg busy;
  reg [15:0] cyc;
  reg [7:0] count;
  reg [12:0] lit;
  wire [12:0] on_s = {3'h0, on_energy_in} << gain_in;
  wire [12:0] off_s = {3'h0, off_energy_in} << gain_in;
  wire [12:0] diff = (lit > off_s) ? lit - off_s : 13'h0000;
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    sat_out <= 1'b0;
    if (reset_in) begin
      busy <= 1'b0;
      cyc <= 16'h0000;
      count <= 8'h00;
      lit <= 13'h0000;
      acc_out <= 18'h00000;
      led_on_out <= 1'b0;
    end else if (start_in) begin
      acc_out <= 18'h00000;
      count <= 8'h00;
      cyc <= 16'h0000;
      busy <= (pulses_in != 8'h00);
      done_out <= (pulses_in == 8'h00);
      led_on_out <= (pulses_in != 8'h00);
    end else if (busy) begin
      cyc <= (cyc == PER_CYC - 1) ? 16'h0000 : cyc + 16'h0001;
      led_on_out <= (cyc == PER_CYC - 1) ? (count + 8'h01 != pulses_in)
                    : (cyc < ON_CYC - 1);
      if (cyc == ON_CYC - 1) begin
        // Clamp so one bright pulse cannot wrap the sum
        lit <= (on_s > `PXSC_ADC_MAX) ? `PXSC_ADC_MAX : on_s;
        sat_out <= (on_s > `PXSC_ADC_MAX);
      end
      if (cyc == PER_CYC - 1) begin
        acc_out <= acc_out + {5'h00, diff};
        count <= count + 8'h01;
        if (count + 8'h01 == pulses_in) begin
          busy <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule

/* hw/pxsc_i2c_slave.v */
// I2C slave: command byte, register pointer and byte transfers
`timescale 1ns/1ps
`include "pxsc_regs.vh"
module pxsc_i2c_slave (
  input wire clock_in,
  input wire reset_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  input wire [7:0] rd_data_in,
  output reg [4:0] ptr_out,
  output reg start_out,
  output reg cmd_out,
  output reg sf_out,
  output reg [4:0] sf_code_out,
  output reg wr_out,
  output reg [7:0] wr_data_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_TACK = 3'd5;
  reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  reg [2:0] state;
  reg [3:0] bitc;
  reg [7:0] sr, txsr;
  reg rw, cmd_phase, auto_inc, drive, mack, bump;
  wire rise = scl_s & ~scl_d;
  wire fall = ~scl_s & scl_d;
  wire start = scl_s & scl_d & sda_d & ~sda_s;
  wire stop = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_out = 1'b0;
  assign sda_oe_out = drive;
  always @(posedge clock_in) begin
    // Two flops per pin before anything reads them
    scl_m <= scl_in;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= sda_in;
    sda_s <= sda_m;
    sda_d <= sda_s;
    start_out <= 1'b0;
    cmd_out <= 1'b0;
    sf_out <= 1'b0;
    wr_out <= 1'b0;
    if (reset_in) begin
      state <= ST_IDLE;
      bitc <= 4'h0;
      sr <= 8'h00;
      txsr <= 8'h00;
      rw <= 1'b0;
      cmd_phase <= 1'b0;
      auto_inc <= 1'b0;
      drive <= 1'b0;
      mack <= 1'b0;
      bump <= 1'b0;
      ptr_out <= 5'h00;
      sf_code_out <= 5'h00;
      wr_data_out <= 8'h00;
    end else if (start) begin
      state <= ST_ADDR;
      bitc <= 4'h0;
      drive <= 1'b0;
      start_out <= 1'b1;
    end else if (stop) begin
      state <= ST_IDLE;
      drive <= 1'b0;
    end else if (rise) begin
      case (state)
        ST_ADDR, ST_RX: begin
          sr <= {sr[6:0], sda_s};
          bitc <= bitc + 4'h1;
        end
        ST_TX: bitc <= bitc + 4'h1;
        ST_TACK: mack <= ~sda_s;
        default: bitc <= bitc;
      endcase
    end else if (fall) begin
      case (state)
        ST_ADDR: if (bitc == 4'h8) begin
          if (sr[7:1] == `PXSC_I2C_ADDR) begin
            state <= ST_ACK;
            rw <= sr[0];
            cmd_phase <= ~sr[0];
            drive <= 1'b1;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_RX: if (bitc == 4'h8) begin
          state <= ST_ACK;
          drive <= 1'b1;
          cmd_phase <= 1'b0;
          if (cmd_phase && sr[`PXSC_CMD_BIT]) begin
            cmd_out <= 1'b1;
            ptr_out <= sr[4:0];
            auto_inc <= (sr[6:5] == `PXSC_TYPE_AUTO);
            sf_out <= (sr[6:5] == `PXSC_TYPE_SF);
            sf_code_out <= sr[4:0];
          end else begin
            wr_out <= 1'b1;
            wr_data_out <= sr;
            // Step the pointer only after the write has landed
            bump <= auto_inc;
          end
        end
        ST_ACK: begin
          bitc <= 4'h0;
          bump <= 1'b0;
          if (bump) ptr_out <= ptr_out + 5'h01;
          state <= rw ? ST_TX : ST_RX;
          txsr <= rd_data_in;
          drive <= rw & ~rd_data_in[7];
        end
        ST_TX: if (bitc == 4'h8) begin
          state <= ST_TACK;
          drive <= 1'b0;
          if (auto_inc) ptr_out <= ptr_out + 5'h01;
        end else begin
          txsr <= {txsr[6:0], 1'b0};
          drive <= ~txsr[6];
        end
        ST_TACK: begin
          bitc <= 4'h0;
          state <= mack ? ST_TX : ST_IDLE;
          txsr <= rd_data_in;
          drive <= mack & ~rd_data_in[7];
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* hw/pxsc_top.v */
// Proximity sensor control: power states, registers, measurement
//
// Functional notes
// - Reset completes into Sleep state
// - I2C start wakes to Idle, checks power bit
// - Power bit clear in Idle returns Sleep
// - Power on waits for prox enable, then runs
// - Cycles repeat while power and prox enabled
// - Interrupt with sleep-after-irq sleeps until command
// - Drive strength picks 100/50/25/12.5 mA
// - Drive reduce divides current by nine
// - LED on 7.3 us every 16.0 us
// - Pulse count programmable one to 255
// - Subtract ambient per pulse, accumulate difference
// - Gain 1x/2x/4x/8x, resets to 1x
// - Integrator saturation sets saturation flag
// - Saturation flag held until special clear
// - Final pulse converts to 16-bit two bytes
// - Conversion time scales, 0xFF is one unit
// - Signed offset shifts result either way
// - Valid flag set first cycle, cleared by disable
// - Init, Accumulate, Wait, ADC; Init and Wait one unit each
`timescale 1ns/1ps
`include "pxsc_regs.vh"
module pxsc_top #(
  parameter UNIT_CYCLES = `PXSC_UNIT_NS / `PXSC_CLK_NS
) (
  input wire clock_in,
  input wire reset_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  input wire [9:0] on_energy_in,
  input wire [9:0] off_energy_in,
  input wire prox_irq_in,
  output wire led_sink_pin_out,
  output reg [9:0] led_ma_x10_out,
  output reg [2:0] power_state_out
);
  localparam ON_CYC = (`PXSC_LED_ON_NS + `PXSC_CLK_NS - 1) / `PXSC_CLK_NS;
  localparam PER_CYC = `PXSC_LED_PER_NS / `PXSC_CLK_NS;
  localparam ST_SLEEP = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_PINIT = 3'd2;
  localparam ST_PACC = 3'd3;
  localparam ST_PWAIT = 3'd4;
  localparam ST_PADC = 3'd5;
  localparam ST_WAIT = 3'd6;

  reg [7:0] enable_control;
  reg [7:0] conversion_time;
  reg [7:0] wait_time;
  reg [7:0] drive_cfg;
  reg [7:0] pulse_count;
  reg [7:0] sense_ctrl;
  reg [7:0] proximity_offset;
  reg [15:0] result;
  reg saturation_flag;
  reg result_valid_flag;
  reg prox_int_flag;
  reg [2:0] state;
  reg [31:0] tick;
  reg [8:0] units;
  reg sai_hold;
  reg acc_start;
  reg [7:0] rd_data;
  reg [15:0] next_result;
  reg [9:0] next_led;

  wire [4:0] ptr;
  wire i2c_start, i2c_cmd, i2c_sf, i2c_wr;
  wire [4:0] sf_code;
  wire [7:0] wr_data;
  wire acc_done, acc_sat, led_on;
  wire [17:0] acc_val;

  wire power_on_bit = enable_control[`PXSC_B_PON];
  wire prox_enable_bit = enable_control[`PXSC_B_PEN];
  wire wait_enable = enable_control[`PXSC_B_WEN];
  wire sleep_after_irq = enable_control[`PXSC_B_SAI];
  wire drive_level_reduce = drive_cfg[`PXSC_B_PDL];
  wire [1:0] led_drive_strength = sense_ctrl[7:6];
  wire [1:0] diode_select = sense_ctrl[5:4];
  wire [1:0] integrator_gain = sense_ctrl[3:2];
  wire sat_clear = i2c_sf && (sf_code == `PXSC_SF_PCLR);
  wire wr_hit = i2c_wr;

  // Host must pick the diode; no light reaches the integrator otherwise
  wire diode_ok = (diode_select != 2'h0);
  wire [9:0] on_gated = diode_ok ? on_energy_in : 10'h000;
  wire [9:0] off_gated = diode_ok ? off_energy_in : 10'h000;

  // 0xFF selects one unit, 0x00 selects 256
  wire [8:0] adc_units = `PXSC_UNITS_TOP - {1'b0, conversion_time};
  wire [8:0] wait_units = `PXSC_UNITS_TOP - {1'b0, wait_time};
  wire unit_end = (tick == UNIT_CYCLES - 1);

  pxsc_i2c_slave u_i2c (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .rd_data_in(rd_data),
    .ptr_out(ptr),
    .start_out(i2c_start),
    .cmd_out(i2c_cmd),
    .sf_out(i2c_sf),
    .sf_code_out(sf_code),
    .wr_out(i2c_wr),
    .wr_data_out(wr_data)
  );

  pxsc_accum #(
    .ON_CYC(ON_CYC),
    .PER_CYC(PER_CYC)
  ) u_accum (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .start_in(acc_start),
    .pulses_in(pulse_count),
    .gain_in(integrator_gain),
    .on_energy_in(on_gated),
    .off_energy_in(off_gated),
    .led_on_out(led_on),
    .done_out(acc_done),
    .sat_out(acc_sat),
    .acc_out(acc_val)
  );

  assign led_sink_pin_out = led_on;

  // Register writes from the host
  always @(posedge clock_in) begin
    if (reset_in) begin
      enable_control <= `PXSC_RST_ZERO;
      conversion_time <= `PXSC_RST_TIME;
      wait_time <= `PXSC_RST_TIME;
      drive_cfg <= `PXSC_RST_ZERO;
      pulse_count <= `PXSC_RST_ZERO;
      sense_ctrl <= `PXSC_RST_ZERO;
      proximity_offset <= `PXSC_RST_ZERO;
    end else if (wr_hit) begin
      case (ptr)
        `PXSC_A_ENABLE: enable_control <= wr_data;
        `PXSC_A_CONVERSION_TIME: conversion_time <= wr_data;
        `PXSC_A_WTIME: wait_time <= wr_data;
        `PXSC_A_DRVCFG: drive_cfg <= wr_data;
        `PXSC_A_PULSE_COUNT: pulse_count <= wr_data;
        `PXSC_A_CTRL: sense_ctrl <= wr_data;
        `PXSC_A_OFFSET: proximity_offset <= wr_data;
        default: enable_control <= enable_control;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (ptr)
      `PXSC_A_ENABLE: rd_data = enable_control;
      `PXSC_A_CONVERSION_TIME: rd_data = conversion_time;
      `PXSC_A_WTIME: rd_data = wait_time;
      `PXSC_A_DRVCFG: rd_data = drive_cfg;
      `PXSC_A_PULSE_COUNT: rd_data = pulse_count;
      `PXSC_A_CTRL: rd_data = sense_ctrl;
      `PXSC_A_STATUS: begin
        rd_data = 8'h00;
        rd_data[`PXSC_B_VALID] = result_valid_flag;
        rd_data[`PXSC_B_PINT] = prox_int_flag;
        rd_data[`PXSC_B_SATURATION_FLAG] = saturation_flag;
      end
      `PXSC_A_PDATAL: rd_data = result[7:0];
      `PXSC_A_PDATAH: rd_data = result[15:8];
      `PXSC_A_OFFSET: rd_data = proximity_offset;
      default: rd_data = 8'h00;
    endcase
  end

  // Scaling, signed offset and clamp, computed every cycle and stored into result at the end of ADC
  reg [26:0] scaled;
  reg signed [28:0] with_off;
  always @* begin
    scaled = acc_val * adc_units;
    with_off = $signed({2'b00, scaled})
      + {{21{proximity_offset[7]}}, proximity_offset};
    if (with_off < 0)
      next_result = 16'h0000;
    else if (with_off > $signed({13'h0000, `PXSC_FULL_SCALE}))
      next_result = `PXSC_FULL_SCALE;
    else
      next_result = with_off[15:0];
  end

  // LED sink current in tenths of a mA
  always @* begin
    next_led = `PXSC_LED_BASE >> led_drive_strength;
    if (drive_level_reduce)
      next_led = next_led / `PXSC_LED_DIV;
  end

  always @(posedge clock_in) begin
    if (reset_in)
      led_ma_x10_out <= 10'h000;
    else
      led_ma_x10_out <= next_led;
  end

  // Status flags; a set in the same cycle as a clear wins
  always @(posedge clock_in) begin
    if (reset_in) begin
      saturation_flag <= 1'b0;
      prox_int_flag <= 1'b0;
      result_valid_flag <= 1'b0;
      result <= 16'h0000;
    end else begin
      if (acc_sat)
        saturation_flag <= 1'b1;
      else if (sat_clear)
        saturation_flag <= 1'b0;
      if (state == ST_PADC && unit_end && units == 9'h001) begin
        result <= next_result;
        result_valid_flag <= 1'b1;
      end else if (!prox_enable_bit) begin
        result_valid_flag <= 1'b0;
      end
      // A set in the ADC-end cycle wins over a clear in that cycle
      if (state == ST_PADC && unit_end && units == 9'h001 && prox_irq_in)
        prox_int_flag <= 1'b1;
      else if (sat_clear)
        prox_int_flag <= 1'b0;
    end
  end

  // Power state machine
  always @(posedge clock_in) begin
    acc_start <= 1'b0;
    if (reset_in) begin
      state <= ST_SLEEP;
      tick <= 32'h0;
      units <= 9'h000;
      sai_hold <= 1'b0;
      power_state_out <= ST_SLEEP;
    end else begin
      power_state_out <= state;
      tick <= unit_end ? 32'h0 : tick + 32'h1;
      if (unit_end && units != 9'h000)
        units <= units - 9'h001;
      case (state)
        ST_SLEEP: begin
          tick <= 32'h0;
          // After an interrupt sleep, only a command byte wakes
          if (sai_hold ? i2c_cmd : i2c_start) begin
            state <= ST_IDLE;
            sai_hold <= 1'b0;
          end
        end
        ST_IDLE: begin
          tick <= 32'h0;
          if (!power_on_bit)
            state <= ST_SLEEP;
          else if (prox_enable_bit) begin
            state <= ST_PINIT;
            units <= 9'h001;
          end
        end
        ST_PINIT: if (unit_end) begin
          state <= ST_PACC;
          acc_start <= 1'b1;
        end
        ST_PACC: begin
          tick <= 32'h0;
          if (acc_done) begin
            state <= ST_PWAIT;
            units <= 9'h001;
          end
        end
        ST_PWAIT: if (unit_end) begin
          state <= ST_PADC;
          units <= adc_units;
        end
        ST_PADC: if (unit_end && units == 9'h001) begin
          if (prox_irq_in && sleep_after_irq) begin
            state <= ST_SLEEP;
            sai_hold <= 1'b1;
          end else if (wait_enable) begin
            state <= ST_WAIT;
            units <= wait_units;
          end else
            state <= ST_IDLE;
        end
        ST_WAIT: if (unit_end && units == 9'h001)
          state <= ST_IDLE;
        default: state <= ST_SLEEP;
      endcase
    end
  end
endmodule

/* tb/pxsc_host.sv */
// Behavioural I2C host driving the sensor's two-wire port
`timescale 1ns/1ps
module pxsc_host (
  input wire clock_in,
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  reg [7:0] rx;
  integer nacks;
  integer i;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    nacks = 0;
  end
  // SCL high 7 clocks, low 9 with the data hold: a 160 ns period
  task hp;
    repeat (7) @(negedge clock_in);
  endtask
  task bit_io(input b);
    begin
      sda_low_out = ~b;
      hp;
      scl_out = 1'b1;
      hp;
      rx = {rx[6:0], sda_in};
      scl_out = 1'b0;
      // Hold data past the fall so it never looks like start or stop
      repeat (2) @(negedge clock_in);
    end
  endtask
  task start;
    begin
      sda_low_out = 1'b1;
      hp;
      scl_out = 1'b0;
      repeat (2) @(negedge clock_in);
    end
  endtask
  task stop;
    begin
      sda_low_out = 1'b1;
      hp;
      scl_out = 1'b1;
      hp;
      sda_low_out = 1'b0;
      hp;
    end
  endtask
  task xfer(input [7:0] d);
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i]);
      bit_io(1'b1);
      if (rx[0])
        nacks = nacks + 1;
    end
  endtask
  task send(input [7:0] c, input [7:0] d, input with_d);
    begin
      start;
      xfer(8'h72);
      xfer(c);
      if (with_d)
        xfer(d);
      stop;
    end
  endtask
  task rd(input [4:0] a, output [7:0] d);
    begin
      send({3'h4, a}, 8'h00, 1'b0);
      start;
      xfer(8'h73);
      for (i = 0; i < 8; i = i + 1)
        bit_io(1'b1);
      d = rx;
      // Host NACK ends the read
      bit_io(1'b1);
      stop;
    end
  endtask
endmodule

/* tb/pxsc_top_checker.sv */
// Port-level assertions for the proximity sensor control block
`timescale 1ns/1ps
module pxsc_top_checker #(
  parameter UNIT_CYCLES = 273000
) (
  input wire clock_in,
  input wire reset_in,
  input wire led_sink_pin_out,
  input wire [9:0] led_ma_x10_out,
  input wire [2:0] power_state_out
);
  reg [11:0] on_len;
  reg [11:0] per_len;
  reg [31:0] st_len;
  reg led_q;
  reg [2:0] ps_q;
  wire moved = power_state_out != ps_q;
  wire led_up = led_sink_pin_out && !led_q;
  // Period count parks outside accumulation so cycle gaps never count
  always @(posedge clock_in) begin
    if (reset_in) begin
      on_len <= 12'h000;
      per_len <= 12'hFFF;
      st_len <= 32'h0;
      led_q <= 1'b0;
      ps_q <= 3'h0;
    end else begin
      led_q <= led_sink_pin_out;
      ps_q <= power_state_out;
      on_len <= led_sink_pin_out ? on_len + 12'h001 : 12'h000;
      if (led_up)
        per_len <= 12'h001;
      else if (power_state_out != 3'h3)
        per_len <= 12'hFFF;
      else if (per_len != 12'hFFF)
        per_len <= per_len + 12'h001;
      st_len <= moved ? 32'h1 : st_len + 32'h1;
    end
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  property p_reset_sleep;
    $fell(reset_in) |-> power_state_out == 3'h0;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep)
    else $error("not asleep after reset");
  property p_wake;
    moved && ps_q == 3'h0 |-> power_state_out == 3'h1;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep left to a state other than idle");
  property p_order;
    moved && power_state_out inside {3'h2, 3'h3, 3'h4, 3'h5}
      |-> ps_q == power_state_out - 3'h1;
  endproperty
  a_order: assert property (p_order)
    else $error("cycle states out of order");
  property p_unit;
    moved && (ps_q == 3'h2 || ps_q == 3'h4) |-> st_len == UNIT_CYCLES;
  endproperty
  a_unit: assert property (p_unit)
    else $error("init or prox wait length wrong");
  property p_led_width;
    $fell(led_sink_pin_out) |-> on_len == 12'h2DA;
  endproperty
  a_led_width: assert property (p_led_width)
    else $error("led on time wrong");
  property p_led_period;
    led_up && per_len != 12'hFFF |-> per_len == 12'h640;
  endproperty
  a_led_period: assert property (p_led_period)
    else $error("led period wrong");
  property p_led_accum;
    led_sink_pin_out |-> ##[0:1] power_state_out == 3'h3;
  endproperty
  a_led_accum: assert property (p_led_accum)
    else $error("led on outside accumulation");
  property p_drive;
    !$past(reset_in) |-> led_ma_x10_out inside {10'h3E8, 10'h1F4,
      10'h0FA, 10'h07D, 10'h06F, 10'h037, 10'h01B, 10'h00D};
  endproperty
  a_drive: assert property (p_drive)
    else $error("led current not a legal setting");
  c_accum: cover property (moved && power_state_out == 3'h3);
  c_pulse: cover property ($rose(led_sink_pin_out));
  c_sai: cover property (moved && ps_q == 3'h5 && power_state_out == 3'h0);
endmodule

/* tb/pxsc_top_bench.sv */
// Self-checking bench for the proximity sensor control block
`timescale 1ns/1ps
module pxsc_top_bench;
  localparam UNITS = 50;
  reg clock_in = 1'b0;
  reg reset_in = 1'b1;
  reg [9:0] on_e = 10'h000;
  reg [9:0] off_e = 10'h000;
  reg irq = 1'b0;
  reg [12:0] rows [0:7];
  reg [7:0] rb;
  integer bad_count = 0;
  integer checked = 0;
  integer pulses = 0;
  integer i;
  wire scl;
  wire host_low;
  wire sda_oe;
  wire led;
  wire [9:0] ma;
  wire [2:0] ps;
  // Open-drain data line with pull-up
  wire sda_line = ~(host_low | sda_oe);
  always #5 clock_in = ~clock_in;
  always @(posedge led) pulses = pulses + 1;
  pxsc_top #(.UNIT_CYCLES(UNITS)) u_pxsc_top (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(),
    .sda_oe_out(sda_oe),
    .on_energy_in(on_e),
    .off_energy_in(off_e),
    .prox_irq_in(irq),
    .led_sink_pin_out(led),
    .led_ma_x10_out(ma),
    .power_state_out(ps)
  );
  pxsc_host u_pxsc_host (
    .clock_in(clock_in),
    .sda_in(sda_line),
    .scl_out(scl),
    .sda_low_out(host_low)
  );
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] c, input [7:0] d);
    u_pxsc_host.send(c, d, 1'b1);
  endtask
  task rd(input [4:0] a, input [7:0] exp);
    begin
      u_pxsc_host.rd(a, rb);
      chk(16'(rb), 16'(exp));
    end
  endtask
  // Bounded so a stuck state machine shows as a mismatch
  task wait_ps(input [2:0] v);
    integer n;
    begin
      n = 0;
      while (ps !== v && n < 20000) begin
        @(negedge clock_in);
        n = n + 1;
      end
      chk(16'(ps), 16'(v));
    end
  endtask
  // Two pulses, ambient fixed at 20; waits for a fresh cycle
  task measure(input [9:0] on_v, input [7:0] offs, input [15:0] exp);
    begin
      on_e = on_v;
      wr(8'h9E, offs);
      wait_ps(3'h2);
      pulses = 0;
      wait_ps(3'h5);
      chk(16'(pulses), 16'h0002);
      wait_ps(3'h1);
      rd(5'h18, exp[7:0]);
      rd(5'h19, exp[15:8]);
    end
  endtask
  task wrap_up;
    begin
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #900000;
    bad_count = bad_count + 1;
    $display("BAD t=%0t timeout got=%h exp=%h", $time, ps, 3'h0);
    wrap_up;
  end
  initial begin
    rows[0] = {2'h0, 1'b1, 10'h06F};
    rows[1] = {2'h1, 1'b0, 10'h1F4};
    rows[2] = {2'h1, 1'b1, 10'h037};
    rows[3] = {2'h2, 1'b0, 10'h0FA};
    rows[4] = {2'h2, 1'b1, 10'h01B};
    rows[5] = {2'h3, 1'b0, 10'h07D};
    rows[6] = {2'h3, 1'b1, 10'h00D};
    rows[7] = {2'h0, 1'b0, 10'h3E8};
    repeat (6) @(negedge clock_in);
    chk(16'(ps), 16'h0000);
    reset_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk(16'(ma), 16'h03E8);
    rd(5'h02, 8'hFF);
    rd(5'h0F, 8'h00);
    rd(5'h1F, 8'h00);
    wr(8'h93, 8'hFF);
    rd(5'h13, 8'h00);
    wait_ps(3'h0);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h8F, {rows[i][12:11], 6'h20});
      wr(8'h8D, {7'h00, rows[i][10]});
      chk(16'(ma), 16'(rows[i][9:0]));
    end
    $display("drive table done");
    wr(8'h8E, 8'h02);
    wr(8'h80, 8'h01);
    // Power bit lands after the start that woke it, so wake again
    rd(5'h00, 8'h01);
    repeat (200) @(negedge clock_in);
    chk(16'(ps), 16'h0001);
    off_e = 10'h014;
    wr(8'h80, 8'h05);
    measure(10'h064, 8'h00, 16'h00A0);
    rd(5'h13, 8'h01);
    wr(8'h8F, 8'h24);
    measure(10'h064, 8'hF0, 16'h0130);
    wr(8'h8F, 8'h28);
    measure(10'h064, 8'h10, 16'h0290);
    wr(8'h8F, 8'h20);
    measure(10'h01E, 8'h80, 16'h0000);
    $display("measurement test done");
    wr(8'h8F, 8'h2C);
    measure(10'h0C8, 8'h00, 16'h06BE);
    rd(5'h13, 8'h41);
    wr(8'h8F, 8'h20);
    measure(10'h064, 8'h00, 16'h00A0);
    rd(5'h13, 8'h41);
    u_pxsc_host.send(8'hE5, 8'h00, 1'b0);
    rd(5'h13, 8'h01);
    $display("saturation test done");
    wr(8'h82, 8'hFE);
    measure(10'h064, 8'h00, 16'h0140);
    wr(8'h80, 8'h01);
    rd(5'h13, 8'h00);
    wait_ps(3'h1);
    irq = 1'b1;
    wr(8'h80, 8'h45);
    wait_ps(3'h5);
    wait_ps(3'h0);
    // A bare start must not wake it; only a command does
    u_pxsc_host.start;
    u_pxsc_host.stop;
    repeat (300) @(negedge clock_in);
    chk(16'(ps), 16'h0000);
    rd(5'h13, 8'h21);
    wait_ps(3'h5);
    chk(16'(u_pxsc_host.nacks), 16'h0000);
    $display("sleep test done");
    wrap_up;
  end
endmodule
bind pxsc_top pxsc_top_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_pxsc_top_checker (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .led_sink_pin_out(led_sink_pin_out),
  .led_ma_x10_out(led_ma_x10_out),
  .power_state_out(power_state_out)
);
